// ==== rtl/rnd_rol_pkg.sv ====
// constants and types for the round / rotate-left execution unit
// assumes one core clock; decoder and register file sit outside
package rnd_rol_pkg;

   // -------------------------------------------------------------
   // data formats
   // -------------------------------------------------------------
   localparam int EXT_W   = 40;
   localparam int INT_W   = 32;
   localparam int EXP_W   = 8;
   localparam int REG_W   = 5;
   localparam int IMM_W   = 16;
   localparam int FLAG_W  = 7;

   localparam logic [EXP_W-1:0] EXP_ZERO = 8'h80;
   localparam logic [EXP_W-1:0] EXP_MAX  = 8'h7F;
   localparam logic [EXP_W-1:0] EXP_MIN  = 8'h81;
   localparam logic [EXP_W-1:0] EXP_ONE  = 8'h01;

   // half of the lowest kept single-precision fraction bit
   localparam logic [31:0]      RND_HALF = 32'h0000_0080;
   localparam logic [EXT_W-1:0] EXT_ZERO = 40'h80_0000_0000;
   localparam logic [EXT_W-1:0] POS_MAX  = 40'h7F_7FFF_FF00;

   // short immediate float: exponent nibble, sign, fraction
   localparam logic [3:0]       IMM_EXP_ZERO = 4'h8;

   // -------------------------------------------------------------
   // register numbers and addressing modes
   // -------------------------------------------------------------
   localparam logic [REG_W-1:0] REG_EXT_LAST = 5'h07;
   localparam logic [REG_W-1:0] REG_LAST     = 5'h1B;

   localparam logic [1:0] SRC_REG = 2'h0;
   localparam logic [1:0] SRC_DIR = 2'h1;
   localparam logic [1:0] SRC_IND = 2'h2;
   localparam logic [1:0] SRC_IMM = 2'h3;

   typedef enum logic [0:0] {
      OP_RND = 1'b0,
      OP_ROL = 1'b1
   } op_t;

   // -------------------------------------------------------------
   // condition flags and register map
   // -------------------------------------------------------------
   typedef struct packed {
      logic latched_underflow_flag;
      logic latched_overflow_flag;
      logic underflow_flag;
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   localparam int BIT_SAT_MODE = 7;

   localparam logic [7:0]  OFS_STATUS = 8'h00;
   localparam logic [7:0]  OFS_RES_LO = 8'h04;
   localparam logic [7:0]  OFS_RES_HI = 8'h08;
   localparam logic [7:0]  OFS_INFO   = 8'h0C;
   localparam logic [7:0]  OFS_COUNT  = 8'h10;
   localparam flags_t      FLAGS_RST  = 7'h00;

endpackage

// ==== rtl/rnd_if.sv ====
// operand and result of the single-precision rounder
// assumes the rounder is purely combinational
`timescale 1ns/100ps
interface rnd_if;
   import rnd_rol_pkg::*;

   logic [EXT_W-1:0] operand;
   logic [EXT_W-1:0] result;
   logic             ovf;
   logic             unf;

   modport unit (input operand, output result, ovf, unf);
   modport user (output operand, input result, ovf, unf);
endinterface

// ==== rtl/fp_round_single.sv ====
// rounds an extended float to the nearest single-precision value
// assumes operand already selected; result is combinational
`timescale 1ns/100ps
module fp_round_single (
   rnd_if.unit port
);
   import rnd_rol_pkg::*;

   // -------------------------------------------------------------
   // round half up, then renormalise
   // -------------------------------------------------------------
   logic [EXP_W-1:0] exp_v;
   logic             sgn;
   logic [31:0]      sum;

   always_comb begin
      exp_v       = port.operand[39:32];
      sgn         = port.operand[31];
      // adding half then truncating picks the more positive value
      sum         = {1'b0, port.operand[30:0]} + RND_HALF;
      port.ovf    = 1'b0;
      port.unf    = 1'b0;
      // low fraction bits forced to zero
      port.result = {exp_v, sgn, sum[30:8], 8'h00};
      if (exp_v == EXP_ZERO) begin
         port.result = EXT_ZERO;
      end else if (sum[31]) begin
         if (!sgn) begin
            // 1.111.. rounds to 2.0
            if (exp_v == EXP_MAX) begin
               port.ovf    = 1'b1;
               port.result = POS_MAX;
            end else begin
               port.result = {exp_v + EXP_ONE, 1'b0, 31'h0000_0000};
            end
         end else begin
            // -1.000.. renormalises to -2.0 one exponent down
            if (exp_v == EXP_MIN) begin
               port.unf    = 1'b1;
               port.result = EXT_ZERO;
            end else begin
               port.result = {exp_v - EXP_ONE, 1'b1, 31'h0000_0000};
            end
         end
      end
   end

endmodule

// ==== rtl/round_and_rotate_left_unit.sv ====
// execution unit for the round and rotate-left instructions
// assumes the decoder supplies one instruction per strobe with its
// operands already fetched; writeback goes to an outside register file
`timescale 1ns/100ps
module round_and_rotate_left_unit (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          op_valid_i,
   input  wire rnd_rol_pkg::op_t              op_code_i,
   input  wire logic [1:0]                    src_mode_i,
   input  wire logic [rnd_rol_pkg::REG_W-1:0] src_reg_i,
   input  wire logic [rnd_rol_pkg::REG_W-1:0] dst_reg_i,
   input  wire logic [rnd_rol_pkg::EXT_W-1:0] reg_src_i,
   input  wire logic [rnd_rol_pkg::EXT_W-1:0] mem_src_i,
   input  wire logic [rnd_rol_pkg::IMM_W-1:0] imm_i,
   input  wire logic [rnd_rol_pkg::EXT_W-1:0] dst_val_i,
   input  wire logic [7:0]                    reg_addr_i,
   input  wire logic [31:0]                   reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic [31:0]                        reg_rdata_o,
   output logic                               wb_valid_o,
   output logic [rnd_rol_pkg::REG_W-1:0]      wb_reg_o,
   output logic [rnd_rol_pkg::EXT_W-1:0]      wb_data_o,
   output logic                               op_error_o,
   output rnd_rol_pkg::flags_t                flags_o,
   output logic                               overflow_saturate_mode_o
);
   import rnd_rol_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      flags_t           flg;
      logic             sat_mode;
      logic             wb_v;
      logic [REG_W-1:0] wb_r;
      logic [EXT_W-1:0] wb_d;
      logic             err;
      logic [REG_W-1:0] last_r;
      logic             last_op;
      logic             last_err;
      logic [15:0]      rnd_cnt;
      logic [15:0]      rol_cnt;
      logic [31:0]      rdata;
   } state_t;

   state_t q;
   state_t d;

   // -------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------
   function automatic logic is_ext_reg(input logic [REG_W-1:0] r);
      is_ext_reg = (r <= REG_EXT_LAST);
   endfunction

   function automatic logic is_any_reg(input logic [REG_W-1:0] r);
      is_any_reg = (r <= REG_LAST);
   endfunction

   // short immediate float widened to the extended format
   function automatic logic [EXT_W-1:0] short_to_ext(
      input logic [IMM_W-1:0] s
   );
      if (s[15:12] == IMM_EXP_ZERO) begin
         short_to_ext = EXT_ZERO;
      end else begin
         short_to_ext = {{4{s[15]}}, s[15:12], s[11], s[10:0],
                         20'h0_0000};
      end
   endfunction

   // -------------------------------------------------------------
   // source selection and rounder
   // -------------------------------------------------------------
   rnd_if rnd ();

   always_comb begin
      unique case (src_mode_i)
         SRC_REG: rnd.operand = reg_src_i;
         SRC_DIR: rnd.operand = mem_src_i;
         SRC_IND: rnd.operand = mem_src_i;
         SRC_IMM: rnd.operand = short_to_ext(imm_i);
      endcase
   end

   fp_round_single u_round (
      .port (rnd.unit)
   );

   // -------------------------------------------------------------
   // operand legality
   // -------------------------------------------------------------
   logic rnd_ok;
   logic rol_ok;
   logic dst_ext;

   always_comb begin
      dst_ext = is_ext_reg(dst_reg_i);
      rnd_ok  = dst_ext &&
                ((src_mode_i != SRC_REG) || is_ext_reg(src_reg_i));
      rol_ok  = is_any_reg(dst_reg_i);
   end

   // -------------------------------------------------------------
   // rotate datapath
   // -------------------------------------------------------------
   logic [INT_W-1:0] rot;
   logic [EXT_W-1:0] rol_res;

   always_comb begin
      rot = {dst_val_i[30:0], dst_val_i[31]};
      if (dst_ext) begin
         rol_res = {dst_val_i[39:32], rot};
      end else begin
         rol_res = {8'h00, rot};
      end
   end

   // -------------------------------------------------------------
   // register read decode
   // -------------------------------------------------------------
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (reg_addr_i)
         OFS_STATUS: rd_word = {24'h00_0000, q.sat_mode, q.flg};
         OFS_RES_LO: rd_word = q.wb_d[31:0];
         OFS_RES_HI: rd_word = {24'h00_0000, q.wb_d[39:32]};
         OFS_INFO:   rd_word = {24'h00_0000, q.last_err,
                                q.last_op, 1'b0, q.last_r};
         OFS_COUNT:  rd_word = {q.rol_cnt, q.rnd_cnt};
         default:    rd_word = 32'h0000_0000;
      endcase
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      d       = q;
      d.wb_v  = 1'b0;
      d.err   = 1'b0;
      d.rdata = 32'h0000_0000;

      if (reg_rd_i) begin
         d.rdata = rd_word;
      end

      // software write first; an accepted instruction in the same cycle then overrides only the flag bits it writes
      if (reg_wr_i && (reg_addr_i == OFS_STATUS)) begin
         d.flg = flags_t'(reg_wdata_i[FLAG_W-1:0]);
         d.sat_mode = reg_wdata_i[BIT_SAT_MODE];
      end

      if (op_valid_i) begin
         d.last_r  = dst_reg_i;
         d.last_op = op_code_i;
         unique case (op_code_i)
            OP_RND: begin
               if (rnd_ok) begin
                  d.wb_v    = 1'b1;
                  d.wb_r    = dst_reg_i;
                  d.wb_d    = rnd.result;
                  d.rnd_cnt = q.rnd_cnt + 16'h0001;
                  d.flg.z   = (rnd.result[39:32] == EXP_ZERO);
                  d.flg.n   = rnd.result[31] &&
                              (rnd.result[39:32] != EXP_ZERO);
                  d.flg.v   = rnd.ovf;
                  d.flg.underflow_flag = rnd.unf;
                  // hardware set wins over a same-cycle clear
                  d.flg.latched_overflow_flag =
                     d.flg.latched_overflow_flag | rnd.ovf;
                  d.flg.latched_underflow_flag =
                     d.flg.latched_underflow_flag | rnd.unf;
                  // carry left as is; mode bit not consulted
                  d.flg.c   = d.flg.c;
               end else begin
                  d.err = 1'b1;
               end
            end
            OP_ROL: begin
               if (rol_ok) begin
                  d.wb_v    = 1'b1;
                  d.wb_r    = dst_reg_i;
                  d.wb_d    = rol_res;
                  d.rol_cnt = q.rol_cnt + 16'h0001;
                  d.flg.n   = rot[31];
                  d.flg.z   = (rot == 32'h0000_0000);
                  d.flg.v   = 1'b0;
                  d.flg.underflow_flag = 1'b0;
                  if (dst_ext) begin
                     d.flg.c = dst_val_i[31];
                  end
               end else begin
                  d.err = 1'b1;
               end
            end
         endcase
         d.last_err = d.err;
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   always_comb begin
      reg_rdata_o              = q.rdata;
      wb_valid_o               = q.wb_v;
      wb_reg_o                 = q.wb_r;
      wb_data_o                = q.wb_d;
      op_error_o               = q.err;
      flags_o                  = q.flg;
      overflow_saturate_mode_o = q.sat_mode;
   end

endmodule

// ==== test/rf_model.sv ====
// register-file model: feeds operands and takes writeback
// assumes the bench preloads regs by hierarchy before an op
`timescale 1ns/100ps
module rf_model
   import rnd_rol_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic [REG_W-1:0] src_reg_i,
   input  wire logic [REG_W-1:0] dst_reg_i,
   input  wire logic             wb_valid_i,
   input  wire logic [REG_W-1:0] wb_reg_i,
   input  wire logic [EXT_W-1:0] wb_data_i,
   output logic      [EXT_W-1:0] src_val_o,
   output logic      [EXT_W-1:0] dst_val_o
);
   logic [EXT_W-1:0] regs [0:31];
   assign src_val_o = regs[src_reg_i];
   // write-through on dst_val_o only: an op right behind a writeback sees the new destination value; src_val_o reads regs
   assign dst_val_o = (wb_valid_i && wb_reg_i == dst_reg_i) ? wb_data_i
                                                           : regs[dst_reg_i];
   always @(posedge clk_i) begin
      if (wb_valid_i) begin
         regs[wb_reg_i] <= wb_data_i;
      end
   end
endmodule

// ==== test/round_and_rotate_left_unit_asserts.sv ====
// port checks for the round / rotate-left unit
// assumes a bind onto the unit; sees only its ports
`timescale 1ns/100ps
module round_and_rotate_left_unit_asserts
   import rnd_rol_pkg::*;
(
   input wire logic             sys_clk_i,
   input wire logic             sys_rst_i,
   input wire logic             op_valid_i,
   input wire op_t              op_code_i,
   input wire logic [1:0]       src_mode_i,
   input wire logic [REG_W-1:0] src_reg_i,
   input wire logic [REG_W-1:0] dst_reg_i,
   input wire logic [EXT_W-1:0] dst_val_i,
   input wire logic             reg_wr_i,
   input wire logic             wb_valid_o,
   input wire logic [REG_W-1:0] wb_reg_o,
   input wire logic [EXT_W-1:0] wb_data_o,
   input wire logic             op_error_o,
   input wire flags_t           flags_o
);
   logic ext_dst;
   logic legal;
   assign ext_dst = dst_reg_i <= REG_EXT_LAST;
   assign legal = (op_code_i == OP_ROL) ? dst_reg_i <= REG_LAST
      : ext_dst && (src_mode_i != SRC_REG || src_reg_i <= REG_EXT_LAST);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // accepted ops with no register write of any kind racing them
   sequence s_rol;
      op_valid_i && legal && op_code_i == OP_ROL && !reg_wr_i;
   endsequence
   sequence s_rnd;
      op_valid_i && legal && op_code_i == OP_RND && !reg_wr_i;
   endsequence
   a_wb_next_cycle: assert property (
      op_valid_i && legal |=> wb_valid_o && !op_error_o
         && wb_reg_o == $past(dst_reg_i)) else $error("no writeback");
   a_bad_refused: assert property (
      op_valid_i && !legal && !reg_wr_i |=> op_error_o && !wb_valid_o
         && $stable(flags_o)) else $error("illegal operand accepted");
   a_rol_data: assert property (s_rol |=> wb_data_o[31:0] ==
      {$past(dst_val_i[30:0]), $past(dst_val_i[31])}) else $error("rotate");
   a_rol_carry: assert property (s_rol |=> flags_o.c ==
      ($past(ext_dst) ? $past(dst_val_i[31]) : $past(flags_o.c)))
      else $error("rotate carry");
   a_rol_sign_zero: assert property (s_rol |=> flags_o.n ==
      wb_data_o[31] && flags_o.z == (wb_data_o[31:0] == 32'h0))
      else $error("rotate sign or zero flag");
   a_rol_clears: assert property (s_rol |=> !flags_o.v
      && !flags_o.underflow_flag && $stable(flags_o.latched_overflow_flag)
      && $stable(flags_o.latched_underflow_flag))
      else $error("rotate v or underflow");
   a_rnd_carry_kept: assert property (
      s_rnd |=> $stable(flags_o.c)) else $error("round touched carry");
   a_rnd_low_zero: assert property (s_rnd |=> wb_data_o[7:0] == 8'h00
      && flags_o.n == wb_data_o[31]) else $error("round low bits or sign");
   a_rnd_zero_flag: assert property (s_rnd |=> flags_o.z ==
      (wb_data_o[39:32] == EXP_ZERO)) else $error("round zero flag");
   a_rnd_latches: assert property (s_rnd |=>
      flags_o.latched_overflow_flag == ($past(flags_o[5]) | flags_o.v)
      && flags_o.latched_underflow_flag == ($past(flags_o[6])
      | flags_o.underflow_flag)) else $error("round latched flags");
endmodule

// ==== test/tb_round_and_rotate_left_unit.sv ====
// self-checking bench for the round / rotate-left unit
// assumes the register-file model and the bound port checker
`timescale 1ns/100ps
module tb_round_and_rotate_left_unit;
   import rnd_rol_pkg::*;
   typedef struct {
      op_t         op;
      logic [1:0]  md;
      logic [4:0]  s;
      logic [4:0]  d;
      logic [39:0] v;
      logic [39:0] r;
      logic [4:0]  f;
      logic        e;
   } row_t;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        op_valid_i = 1'b0;
   op_t         op_code_i = OP_RND;
   logic [1:0]  src_mode_i = 2'h0;
   logic [4:0]  src_reg_i = 5'h00;
   logic [4:0]  dst_reg_i = 5'h00;
   logic [39:0] mem_src_i = 40'h0;
   logic [15:0] imm_i = 16'h0000;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [39:0] reg_src_i;
   logic [39:0] dst_val_i;
   logic [31:0] reg_rdata_o;
   logic        wb_valid_o;
   logic [4:0]  wb_reg_o;
   logic [39:0] wb_data_o;
   logic        op_error_o;
   flags_t      flags_o;
   logic        overflow_saturate_mode_o;
   flags_t      ef = FLAGS_RST;
   int          failures = 0;
   int          comparisons = 0;
   // f is {under,n,z,v,c}; e marks a refused operand
   row_t        tbl [13] = '{
      '{OP_RND,2'h0,5'h05,5'h02,40'h0733C16EEF,40'h0733C16F00,5'h00,1'b0},
      '{OP_RND,2'h1,5'h09,5'h00,40'h0100000080,40'h0100000100,5'h00,1'b0},
      '{OP_RND,2'h2,5'h00,5'h01,40'h0180000080,40'h0180000100,5'h08,1'b0},
      '{OP_RND,2'h3,5'h00,5'h04,40'h1400,40'h0140000000,5'h00,1'b0},
      '{OP_RND,2'h0,5'h07,5'h07,40'h8012345678,40'h8000000000,5'h04,1'b0},
      '{OP_RND,2'h0,5'h06,5'h06,40'h7F7FFFFFC0,40'h7F7FFFFF00,5'h02,1'b0},
      '{OP_RND,2'h0,5'h00,5'h05,40'h81FFFFFFC0,40'h8000000000,5'h14,1'b0},
      '{OP_RND,2'h0,5'h00,5'h08,40'h0,40'h0,5'h00,1'b1},
      '{OP_RND,2'h0,5'h08,5'h00,40'h0,40'h0,5'h00,1'b1},
      '{OP_ROL,2'h0,5'h00,5'h03,40'h0080025CD4,40'h000004B9A9,5'h01,1'b0},
      '{OP_ROL,2'h0,5'h00,5'h1B,40'h1280000000,40'h0000000001,5'h01,1'b0},
      '{OP_ROL,2'h0,5'h00,5'h1C,40'h0,40'h0,5'h00,1'b1},
      '{OP_ROL,2'h0,5'h00,5'h00,40'h0,40'h0,5'h04,1'b0}};
   always #25 sys_clk_i = ~sys_clk_i;
   round_and_rotate_left_unit dut_u (
      .sys_clk_i, .sys_rst_i, .op_valid_i, .op_code_i, .src_mode_i,
      .src_reg_i, .dst_reg_i, .reg_src_i, .mem_src_i, .imm_i, .dst_val_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .wb_valid_o, .wb_reg_o, .wb_data_o, .op_error_o, .flags_o,
      .overflow_saturate_mode_o);
   rf_model model_u (
      .clk_i(sys_clk_i), .src_reg_i, .dst_reg_i, .wb_valid_i(wb_valid_o),
      .wb_reg_i(wb_reg_o), .wb_data_i(wb_data_o), .src_val_o(reg_src_i),
      .dst_val_o(dst_val_i));
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic test_done();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(40'(reg_rdata_o), 40'(e));
   endtask
   task automatic run(input row_t r);
      @(posedge sys_clk_i);
      if (r.op == OP_ROL) model_u.regs[r.d] = r.v;
      else if (r.md == SRC_REG) model_u.regs[r.s] = r.v;
      mem_src_i <= r.v;
      imm_i <= r.v[15:0];
      op_valid_i <= 1'b1;
      op_code_i <= r.op;
      src_mode_i <= r.md;
      src_reg_i <= r.s;
      dst_reg_i <= r.d;
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1;
      chk(40'(wb_valid_o), 40'(!r.e));
      chk(40'(op_error_o), 40'(r.e));
      if (!r.e) chk(wb_data_o, r.r);
      chk(40'(flags_o), 40'(ef));
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(40'(flags_o), 40'h0);
      foreach (tbl[i]) begin
         if (!tbl[i].e) begin
            ef = {ef.latched_underflow_flag | tbl[i].f[4],
                  ef.latched_overflow_flag | tbl[i].f[1], tbl[i].f};
         end
         run(tbl[i]);
      end
      rd(OFS_STATUS, 32'h0000_0064);
      rd(OFS_COUNT, 32'h0003_0007);
      wr(OFS_STATUS, 32'h0000_00E0);
      chk(40'(overflow_saturate_mode_o), 40'h1);
      // two rotates back to back, mode bit set
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= OP_ROL;
      dst_reg_i <= 5'h03;
      repeat (2) @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1;
      chk(wb_data_o, 40'h000012E6A4);
      chk(40'(flags_o), 40'h60);
      wr(OFS_RES_LO, 32'hFFFF_FFFF);
      rd(OFS_RES_LO, 32'h0012_E6A4);
      rd(8'h20, 32'h0);
      // round with carry and mode bit set: carry must survive
      wr(OFS_STATUS, 32'h0000_0081);
      ef = 7'h01;
      run('{OP_RND, 2'h3, 5'h00, 5'h02, 40'h1400, 40'h0140000000,
            5'h01, 1'b0});
      rd(OFS_RES_HI, 32'h0000_0001);
      rd(OFS_INFO, 32'h0000_0002);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(40'(flags_o), 40'h0);
      rd(OFS_STATUS, 32'h0);
      test_done();
   end
   // the run needs under 100 cycles; 4000 cycles means a hang
   initial begin
      #200_000;
      failures++;
      test_done();
   end
endmodule
bind round_and_rotate_left_unit round_and_rotate_left_unit_asserts chk_u (
   .sys_clk_i, .sys_rst_i, .op_valid_i, .op_code_i, .src_mode_i,
   .src_reg_i, .dst_reg_i, .dst_val_i, .reg_wr_i, .wb_valid_o, .wb_reg_o,
   .wb_data_o, .op_error_o, .flags_o);
